// *** verilog/diopl_regs.svh ***
// Overview of operation
// (RULE1) Scanner samples every channel each 20 ms into a history array.
// (RULE2) Input point evaluates every 250 ms, producing raw and coded values.
// (RULE3) A change passes only after the configured count of agreeing samples; the code caps counts above 8 at the history depth of 8.
// (RULE4) Filter works on stored history; raw value uses filtered samples only.
// (RULE5) Sixteen-channel input point: raw is the whole word, coded is undefined.
// (RULE6) Driven output channels are read back through the scanner path.
// (RULE7) Output point first channel lies in 1-32, start of a consecutive run.
// (RULE8) Output point covers 0 to 8 consecutive channels; the 4-bit count field allows up to 15.
// (RULE9) Inactive code deactivates the output, active code activates it.
// (RULE10) Nonzero pulse ends activation after that many tenths; zero holds it.
// (RULE11) Output changes only on command, never by periodic evaluation.
// (RULE12) On link loss with watchdog present, output takes the fallback value.
// (RULE13) Without a watchdog, going offline leaves the output unchanged.
// (RULE14) Reporting high, low or off; high first; output default is off.
// (RULE15) Nonzero max interval up to 255 s forces a report while enabled.
// (RULE16) Output status byte: 0 no error, 3 config change, 4 checksum error.
// (RULE17) A CRC-16 is kept over each point's static configuration.
// (RULE18) Invert set treats contacts as normally closed, else normally open.
// (RULE19) Latching toggles the input value on each sensed closure.
// (RULE20) Input status byte reports 6 for a change not yet through the filter.
// (RULE21) Activate during a pulse restarts the pulse from full duration.
`ifndef DIOPL_REGS_SVH
`define DIOPL_REGS_SVH

`define DIOPL_CLK_KHZ        50000
`define DIOPL_SCAN_MS        20
`define DIOPL_EVAL_MS        250
`define DIOPL_TENTH_MS       100
`define DIOPL_SCAN_CYC       (`DIOPL_SCAN_MS * `DIOPL_CLK_KHZ)
`define DIOPL_EVAL_CYC       (`DIOPL_EVAL_MS * `DIOPL_CLK_KHZ)
`define DIOPL_TENTH_CYC      (`DIOPL_TENTH_MS * `DIOPL_CLK_KHZ)
`define DIOPL_TENTHS_PER_SEC 4'hA

`define DIOPL_OFF_DI_CFG     8'h00
`define DIOPL_OFF_DI_VAL     8'h04
`define DIOPL_OFF_DI_CRC     8'h08
`define DIOPL_OFF_DO_CFG     8'h0C
`define DIOPL_OFF_DO_CODES   8'h10
`define DIOPL_OFF_DO_CMD     8'h14
`define DIOPL_OFF_DO_VAL     8'h18
`define DIOPL_OFF_DO_CRC     8'h1C
`define DIOPL_OFF_COS_NEXT   8'h20

// DI_CFG: [5:0] channel, [10:6] count, [14:11] filter, [15] invert,
// [16] latch, [18:17] report, [26:19] max interval
`define DIOPL_DI_CFG_RST     32'h01E4_1041
// DO_CFG: [5:0] channel, [9:6] count, [10] contact sense, [12:11] report,
// [20:13] max interval, [28:21] pulse
`define DIOPL_DO_CFG_RST     32'h0000_0041
// DO_CODES: [7:0] inactive, [15:8] active, [23:16] fallback, [24] watchdog
`define DIOPL_DO_CODES_RST   32'h0000_0100

`define DIOPL_ST_OK          8'h00
`define DIOPL_ST_CFG_CHG     8'h03
`define DIOPL_ST_CRC_ERR     8'h04
`define DIOPL_ST_UNFILT      8'h06
`define DIOPL_CODE_UNDEF     8'hFF
`define DIOPL_CRC_POLY       16'h8005
`define DIOPL_CRC_INIT       16'hFFFF
`define DIOPL_HIST_DEPTH     8
`define DIOPL_DI_MAX_CH      5'h10

`endif

// *** verilog/diopl_pkg.sv ***
package diopl_pkg;

  typedef enum logic [1:0] {
    REP_OFF  = 2'h0,
    REP_LOW  = 2'h1,
    REP_HIGH = 2'h2
  } diopl_report_type;

  typedef struct packed {
    logic [4:0]       spare;
    logic [7:0]       max_interval;
    diopl_report_type report;
    logic             latch;
    logic             invert;
    logic [3:0]       filter;
    logic [4:0]       channel_count;
    logic [5:0]       channel;
  } diopl_di_cfg_type;

  typedef struct packed {
    logic [2:0]       spare;
    logic [7:0]       pulse;
    logic [7:0]       max_interval;
    diopl_report_type report;
    logic             output_contact_sense;
    logic [3:0]       channel_count;
    logic [5:0]       channel;
  } diopl_do_cfg_type;

  typedef struct packed {
    logic [6:0] spare;
    logic       comm_watchdog;
    logic [7:0] link_loss_fallback;
    logic [7:0] active_code;
    logic [7:0] inactive_code;
  } diopl_do_codes_type;

  typedef enum logic [2:0] {
    DO_OFF   = 3'b001,
    DO_ON    = 3'b010,
    DO_PULSE = 3'b100
  } diopl_do_state_type;

endpackage

// *** verilog/diopl_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "diopl_regs.svh"

module diopl_top #(
  parameter int SCAN_CYC  = `DIOPL_SCAN_CYC,
  parameter int EVAL_CYC  = `DIOPL_EVAL_CYC,
  parameter int TENTH_CYC = `DIOPL_TENTH_CYC
) (
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RSTN,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Field channels
  input  wire logic [31:0] DIN,
  output logic      [31:0] DOUT,
  output logic      [31:0] DOUT_EN,
  // Link supervision and reporting
  input  wire logic        COMM_LOST,
  output logic      [1:0]  COS_PENDING
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] crc16(input logic [31:0] d);
    logic [15:0] c;
    c = `DIOPL_CRC_INIT;
    for (int i = 31; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `DIOPL_CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  // Channels are numbered from 1; channel 0 is treated as 1
  function automatic logic [31:0] chan_mask(input logic [5:0] ch, input logic [4:0] n);
    logic [63:0] m;
    m = ((64'h1 << n) - 64'h1) << ((ch == 6'h00) ? 6'h00 : ch - 6'h01);
    return m[31:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  diopl_pkg::diopl_di_cfg_type   di_cfg_r;
  diopl_pkg::diopl_do_cfg_type   do_cfg_r;
  diopl_pkg::diopl_do_codes_type do_codes_r;
  diopl_pkg::diopl_do_state_type do_state_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic [15:0] di_crc_r;
  logic [15:0] do_crc_r;
  logic        di_chg_r;
  logic        do_chg_r;
  logic        apb_wr;
  logic        apb_rd;
  logic        addr_ok;
  logic [31:0] rd_mux;

  assign apb_wr  = PSEL & PENABLE & PWRITE;
  assign apb_rd  = PSEL & PENABLE & ~PWRITE;
  assign PREADY  = 1'b1;
  assign PRDATA  = prdata_r;
  assign PSLVERR = pslverr_r;

  always_comb begin
    case (PADDR)
      `DIOPL_OFF_DI_CFG, `DIOPL_OFF_DI_VAL, `DIOPL_OFF_DI_CRC, `DIOPL_OFF_DO_CFG,
      `DIOPL_OFF_DO_CODES, `DIOPL_OFF_DO_CMD, `DIOPL_OFF_DO_VAL, `DIOPL_OFF_DO_CRC,
      `DIOPL_OFF_COS_NEXT: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Configuration registers; each write also refreshes the stored checksum
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      di_cfg_r   <= `DIOPL_DI_CFG_RST;
      do_cfg_r   <= `DIOPL_DO_CFG_RST;
      do_codes_r <= `DIOPL_DO_CODES_RST;
      di_crc_r   <= crc16(`DIOPL_DI_CFG_RST);
      do_crc_r   <= crc16(`DIOPL_DO_CFG_RST ^ `DIOPL_DO_CODES_RST);
    end else if (apb_wr) begin
      if (PADDR == `DIOPL_OFF_DI_CFG) begin
        di_cfg_r <= PWDATA;
        di_crc_r <= crc16(PWDATA); // see (RULE17)
      end
      if (PADDR == `DIOPL_OFF_DO_CFG) begin
        do_cfg_r <= PWDATA;
        do_crc_r <= crc16(PWDATA ^ do_codes_r); // see (RULE17)
      end
      if (PADDR == `DIOPL_OFF_DO_CODES) begin
        do_codes_r <= PWDATA;
        do_crc_r   <= crc16(do_cfg_r ^ PWDATA); // see (RULE17)
      end
    end
  end

  // Config-change flags clear when the point's value register is read; a write wins
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      di_chg_r <= 1'b0;
      do_chg_r <= 1'b0;
    end else begin
      if (apb_wr && PADDR == `DIOPL_OFF_DI_CFG)
        di_chg_r <= 1'b1;
      else if (apb_rd && PADDR == `DIOPL_OFF_DI_VAL)
        di_chg_r <= 1'b0;
      if (apb_wr && (PADDR == `DIOPL_OFF_DO_CFG || PADDR == `DIOPL_OFF_DO_CODES))
        do_chg_r <= 1'b1;
      else if (apb_rd && PADDR == `DIOPL_OFF_DO_VAL)
        do_chg_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time base
  logic [31:0] scan_cnt_r;
  logic [31:0] eval_cnt_r;
  logic [31:0] tenth_cnt_r;
  logic [3:0]  sec_cnt_r;
  logic        scan_tick;
  logic        eval_tick;
  logic        tenth_tick;
  logic        sec_tick;

  assign scan_tick  = scan_cnt_r == 32'(SCAN_CYC - 1);
  assign eval_tick  = eval_cnt_r == 32'(EVAL_CYC - 1);
  assign tenth_tick = tenth_cnt_r == 32'(TENTH_CYC - 1);
  assign sec_tick   = tenth_tick && sec_cnt_r == `DIOPL_TENTHS_PER_SEC - 4'h1;

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      scan_cnt_r  <= 32'h0000_0000;
      eval_cnt_r  <= 32'h0000_0000;
      tenth_cnt_r <= 32'h0000_0000;
      sec_cnt_r   <= 4'h0;
    end else begin
      scan_cnt_r  <= scan_tick ? 32'h0000_0000 : scan_cnt_r + 32'h1;
      eval_cnt_r  <= eval_tick ? 32'h0000_0000 : eval_cnt_r + 32'h1;
      tenth_cnt_r <= tenth_tick ? 32'h0000_0000 : tenth_cnt_r + 32'h1;
      if (tenth_tick)
        sec_cnt_r <= sec_tick ? 4'h0 : sec_cnt_r + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scanner and filter
  logic [31:0] hist_r [`DIOPL_HIST_DEPTH];
  logic [31:0] sample;
  logic [31:0] agree;
  logic [31:0] filt_r;
  logic [31:0] cond_prev_r;
  logic [31:0] latched_r;
  logic [31:0] cond;
  logic [31:0] di_vec;
  logic [31:0] di_mask;
  logic [31:0] di_shift;
  logic [15:0] di_low;
  logic [15:0] di_raw_nxt;
  logic [15:0] di_raw_r;
  logic [7:0]  di_coded;
  logic        unfilt_r;
  logic [3:0]  flt;

  // Driven channels read back their own drive instead of the pin
  assign sample = (DIN & ~DOUT_EN) | (DOUT & DOUT_EN); // see (RULE6)

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int k = 0; k < `DIOPL_HIST_DEPTH; k++)
        hist_r[k] <= 32'h0000_0000;
    end else if (scan_tick) begin
      hist_r[0] <= sample; // see (RULE1)
      for (int k = 1; k < `DIOPL_HIST_DEPTH; k++)
        hist_r[k] <= hist_r[k-1];
    end
  end

  // Filter of 0 behaves as 1; the history caps it at its depth
  assign flt = (di_cfg_r.filter == 4'h0) ? 4'h1 :
               (di_cfg_r.filter > 4'h8) ? 4'h8 : di_cfg_r.filter;

  for (genvar j = 0; j < 32; j++) begin : g_agree
    always_comb begin
      agree[j] = 1'b1;
      for (int k = 1; k < `DIOPL_HIST_DEPTH; k++)
        if (k < flt && hist_r[k][j] != hist_r[0][j])
          agree[j] = 1'b0; // see (RULE3)
    end
  end

  assign cond       = filt_r ^ {32{di_cfg_r.invert}}; // see (RULE18)
  assign di_vec     = di_cfg_r.latch ? latched_r : cond;
  assign di_mask    = chan_mask(di_cfg_r.channel, di_cfg_r.channel_count);
  assign di_shift   = di_vec >> ((di_cfg_r.channel == 6'h00) ? 6'h00 : di_cfg_r.channel - 6'h01);
  assign di_low     = (di_cfg_r.channel_count >= `DIOPL_DI_MAX_CH) ? 16'hFFFF :
                      16'((17'h1 << di_cfg_r.channel_count) - 17'h1);
  assign di_raw_nxt = di_shift[15:0] & di_low; // see (RULE4)
  assign di_coded   = (di_cfg_r.channel_count >= `DIOPL_DI_MAX_CH) ?
                      `DIOPL_CODE_UNDEF : {6'h00, di_raw_r[1:0]}; // see (RULE5)

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      filt_r   <= 32'h0000_0000;
      unfilt_r <= 1'b0;
    end else if (eval_tick) begin
      filt_r   <= (hist_r[0] & agree) | (filt_r & ~agree); // see (RULE3)
      unfilt_r <= |(di_mask & ~agree & (hist_r[0] ^ filt_r)); // see (RULE20)
    end
  end

  // Latch toggles on a rising edge of the sense-adjusted value
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cond_prev_r <= 32'h0000_0000;
      latched_r   <= 32'h0000_0000;
      di_raw_r    <= 16'h0000;
    end else begin
      cond_prev_r <= cond;
      latched_r   <= latched_r ^ (cond & ~cond_prev_r); // see (RULE19)
      if (eval_tick)
        di_raw_r <= di_raw_nxt; // see (RULE2)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output point
  logic [7:0]  pulse_r;
  logic        lost_prev_r;
  logic        cmd_wr;
  logic        lost_rise;
  logic        do_go_on;
  logic        do_go_off;
  logic [7:0]  do_code;
  logic        do_active;
  logic [31:0] do_mask;
  logic [7:0]  do_raw;

  assign cmd_wr    = apb_wr && PADDR == `DIOPL_OFF_DO_CMD;
  assign lost_rise = COMM_LOST && !lost_prev_r && do_codes_r.comm_watchdog; // see (RULE13)
  assign do_code   = lost_rise ? do_codes_r.link_loss_fallback : PWDATA[7:0]; // see (RULE12)
  assign do_go_on  = (cmd_wr || lost_rise) && do_code == do_codes_r.active_code; // see (RULE9)
  assign do_go_off = (cmd_wr || lost_rise) && do_code == do_codes_r.inactive_code;
  assign do_active = do_state_r != diopl_pkg::DO_OFF;
  assign do_mask   = chan_mask(do_cfg_r.channel, {1'b0, do_cfg_r.channel_count}); // see (RULE7)
  assign do_raw    = do_active ? 8'((9'h001 << do_cfg_r.channel_count) - 9'h001) : 8'h00;

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN)
      lost_prev_r <= 1'b0;
    else
      lost_prev_r <= COMM_LOST;
  end

  // Driven only by commands or link loss; the pulse timer is the only self-change
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      do_state_r <= diopl_pkg::DO_OFF;
      pulse_r    <= 8'h00;
    end else if (do_go_on) begin
      pulse_r    <= do_cfg_r.pulse; // see (RULE21)
      do_state_r <= (do_cfg_r.pulse != 8'h00) ? diopl_pkg::DO_PULSE : diopl_pkg::DO_ON; // see (RULE11)
    end else if (do_go_off) begin
      do_state_r <= diopl_pkg::DO_OFF;
    end else begin
      case (do_state_r)
        diopl_pkg::DO_PULSE: begin
          if (tenth_tick) begin
            pulse_r <= pulse_r - 8'h01;
            if (pulse_r <= 8'h01)
              do_state_r <= diopl_pkg::DO_OFF; // see (RULE10)
          end
        end
        diopl_pkg::DO_ON,
        diopl_pkg::DO_OFF: do_state_r <= do_state_r;
        default: do_state_r <= diopl_pkg::DO_OFF;
      endcase
    end
  end

  // Channel count field limits the run to 0-15 channels
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      DOUT    <= 32'h0000_0000;
      DOUT_EN <= 32'h0000_0000;
    end else begin
      DOUT    <= do_mask & {32{do_active ^ do_cfg_r.output_contact_sense}}; // see (RULE8)
      DOUT_EN <= do_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Change-of-state reporting
  logic [1:0] pend_r;
  logic [7:0] di_age_r;
  logic [7:0] do_age_r;
  logic       do_prev_r;
  logic [1:0] pend_set;
  logic [1:0] pend_clr;
  logic       di_rep;
  logic       do_rep;
  logic       di_max;
  logic       do_max;
  logic       pick_do;
  logic       cos_rd;

  assign di_rep  = di_cfg_r.report != diopl_pkg::REP_OFF;
  assign do_rep  = do_cfg_r.report != diopl_pkg::REP_OFF; // see (RULE14)
  assign di_max  = sec_tick && di_cfg_r.max_interval != 8'h00 &&
                   di_age_r + 8'h01 >= di_cfg_r.max_interval; // see (RULE15)
  assign do_max  = sec_tick && do_cfg_r.max_interval != 8'h00 &&
                   do_age_r + 8'h01 >= do_cfg_r.max_interval;
  assign pend_set[0] = di_rep && ((eval_tick && di_raw_nxt != di_raw_r) || di_max);
  assign pend_set[1] = do_rep && (do_active != do_prev_r || do_max);
  // High priority first; equal priority favours the input point
  assign pick_do = pend_r[1] && (!pend_r[0] || (do_cfg_r.report == diopl_pkg::REP_HIGH &&
                   di_cfg_r.report != diopl_pkg::REP_HIGH)); // see (RULE14)
  assign cos_rd  = apb_rd && PADDR == `DIOPL_OFF_COS_NEXT;
  assign pend_clr = cos_rd ? (pick_do ? 2'b10 : {1'b0, pend_r[0]}) : 2'b00;
  assign COS_PENDING = pend_r;

  // New events win over a clear in the same cycle
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pend_r    <= 2'b00;
      do_prev_r <= 1'b0;
      di_age_r  <= 8'h00;
      do_age_r  <= 8'h00;
    end else begin
      pend_r    <= ((pend_r & ~pend_clr) | pend_set) & {do_rep, di_rep};
      do_prev_r <= do_active;
      if (pend_set[0] || pend_clr[0])
        di_age_r <= 8'h00;
      else if (sec_tick && di_age_r != 8'hFF)
        di_age_r <= di_age_r + 8'h01;
      if (pend_set[1] || pend_clr[1])
        do_age_r <= 8'h00;
      else if (sec_tick && do_age_r != 8'hFF)
        do_age_r <= do_age_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data is captured in the setup cycle, so there are no wait states
  logic [7:0] di_st;
  logic [7:0] do_st;

  assign di_st = (crc16(di_cfg_r) != di_crc_r) ? `DIOPL_ST_CRC_ERR :
                 di_chg_r ? `DIOPL_ST_CFG_CHG :
                 unfilt_r ? `DIOPL_ST_UNFILT : `DIOPL_ST_OK; // see (RULE20)
  assign do_st = (crc16(do_cfg_r ^ do_codes_r) != do_crc_r) ? `DIOPL_ST_CRC_ERR :
                 do_chg_r ? `DIOPL_ST_CFG_CHG : `DIOPL_ST_OK; // see (RULE16)

  always_comb begin
    case (PADDR)
      `DIOPL_OFF_DI_CFG:   rd_mux = di_cfg_r;
      `DIOPL_OFF_DI_VAL:   rd_mux = {di_st, di_coded, di_raw_r};
      `DIOPL_OFF_DI_CRC:   rd_mux = {16'h0000, di_crc_r};
      `DIOPL_OFF_DO_CFG:   rd_mux = do_cfg_r;
      `DIOPL_OFF_DO_CODES: rd_mux = do_codes_r;
      `DIOPL_OFF_DO_VAL:   rd_mux = {8'h00, do_st, 7'h00, do_active, do_raw};
      `DIOPL_OFF_DO_CRC:   rd_mux = {16'h0000, do_crc_r};
      `DIOPL_OFF_COS_NEXT: rd_mux = {30'h0000_0000, pick_do, |pend_r};
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      prdata_r  <= PWRITE ? 32'h0000_0000 : rd_mux;
      pslverr_r <= !addr_ok;
    end
  end

endmodule

`default_nettype wire

// *** bench/diopl_top_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "diopl_regs.svh"

module diopl_top_properties #(
  parameter int TENTH_CYC = `DIOPL_TENTH_CYC
) (
  // Clock and reset
  input wire logic        SYS_CLK,
  input wire logic        RSTN,
  // APB slave
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  // Field and link
  input wire logic [31:0] DOUT,
  input wire logic [31:0] DOUT_EN,
  input wire logic        COMM_LOST,
  input wire logic [1:0]  COS_PENDING
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  ////////////////////////////////////////////////////////////////////////////////
  diopl_pkg::diopl_do_cfg_type   cfg_r;
  diopl_pkg::diopl_do_codes_type codes_r;
  logic [3:0]                    quiet_r;
  logic [11:0]                   on_r;
  logic [63:0]                   m;
  logic                          wr;
  logic                          cmd;
  logic                          on;
  logic                          ok;
  assign wr = PSEL && PENABLE && PWRITE && PREADY;
  assign cmd = wr && PADDR == 8'h14;
  assign on = |(DOUT & DOUT_EN);
  // Single-tenth pulses may end before the check, so they are left out
  assign ok = !cfg_r.output_contact_sense && cfg_r.channel_count != 4'h0 && cfg_r.pulse != 8'h01;
  assign m = ((64'h1 << cfg_r.channel_count) - 64'h1) << (cfg_r.channel - 6'h1);
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cfg_r <= `DIOPL_DO_CFG_RST;
      codes_r <= `DIOPL_DO_CODES_RST;
    end else if (wr && PADDR == 8'h0C) begin
      cfg_r <= PWDATA;
    end else if (wr && PADDR == 8'h10) begin
      codes_r <= PWDATA;
    end
  end
  // Quiet time since the last cause that may move the outputs
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) quiet_r <= 4'h0;
    else if (wr || $changed(COMM_LOST)) quiet_r <= 4'h0;
    else if (quiet_r != 4'hF) quiet_r <= quiet_r + 4'h1;
  end
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) on_r <= 12'h0;
    else if ((cmd && PWDATA[7:0] == codes_r.active_code) || !on) on_r <= 12'h0;
    else if (on_r != 12'hFFF) on_r <= on_r + 12'h1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  cmd_on_a: assert property (cmd && PWDATA[7:0] == codes_r.active_code && ok |-> ##2 on)
    else $error("active command did not drive the output");
  cmd_off_a: assert property (cmd && PWDATA[7:0] == codes_r.inactive_code && ok |-> ##2 !on)
    else $error("inactive command did not release the output");
  out_hold_a: assert property (quiet_r >= 4'h3 && cfg_r.pulse == 8'h00 |-> $stable(DOUT))
    else $error("output moved without a command");
  pulse_len_a: assert property (cfg_r.pulse != 8'h00 && on |-> on_r <= cfg_r.pulse * TENTH_CYC + 3)
    else $error("pulse lasted too long");
  en_map_a: assert property (quiet_r >= 4'h3 |-> DOUT_EN == m[31:0])
    else $error("owned channels do not match the configuration");
  link_fb_a: assert property ($rose(COMM_LOST) && codes_r.comm_watchdog && ok
    && codes_r.link_loss_fallback == codes_r.active_code |-> ##[1:4] on)
    else $error("fallback not applied on link loss");
  link_none_a: assert property ($rose(COMM_LOST) && !codes_r.comm_watchdog && cfg_r.pulse == 8'h00
    && !wr |=> $stable(DOUT) [*3])
    else $error("output changed on link loss without watchdog");
  cos_off_a: assert property (quiet_r >= 4'h2 && cfg_r.report == diopl_pkg::REP_OFF
    |-> !COS_PENDING[1])
    else $error("report pending while reporting is off");
  cover property (cmd && cfg_r.pulse != 8'h00);
  cover property ($rose(COMM_LOST) && codes_r.comm_watchdog);
  cover property (COS_PENDING == 2'h3);
endmodule

bind diopl_top diopl_top_properties #(.TENTH_CYC(TENTH_CYC)) diopl_top_properties_i (
  .SYS_CLK(SYS_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .DOUT(DOUT), .DOUT_EN(DOUT_EN),
  .COMM_LOST(COMM_LOST), .COS_PENDING(COS_PENDING));
`default_nettype wire

// *** bench/diopl_field.sv ***
`timescale 1ns/1ns
`default_nettype none

module diopl_field (
  // Field contact levels
  input  wire logic [31:0] field,
  // Output channels
  input  wire logic [31:0] dout,
  input  wire logic [31:0] dout_en,
  // Input channels
  output logic      [31:0] din
);
  // An owned channel shows the driven level, so the scanner reads it back
  assign din = (dout & dout_en) | (field & ~dout_en);
endmodule
`default_nettype wire

// *** bench/diopl_top_tb.sv ***
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end

module diopl_top_tb;
  typedef struct packed {
    logic [31:0] m;
    logic [31:0] e;
    logic        er;
  } diopl_exp_type;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] field = 32'h0;
  logic        lost = 1'b0;
  wire logic [31:0] prd, dout, den, din;
  wire logic        rdy, err;
  wire logic [1:0]  cos;
  int n_fail = 0;
  int checked = 0;
  diopl_exp_type q[$];
  diopl_exp_type x;
  logic [31:0] v;
  logic [8:0]  cmds [5] = '{9'h10A, 9'h005, 9'h10A, 9'h133, 9'h005};
  logic [63:0] ens [4] = '{{32'h1011, 32'h0}, {32'h10D1, 32'h7_0000},
                           {32'h1211, 32'hFF_0000}, {32'h1051, 32'h1_0000}};
  always #10 clk = ~clk;
  diopl_top #(.SCAN_CYC(4), .EVAL_CYC(10), .TENTH_CYC(5)) diopl_top_i (
    .SYS_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err),
    .DIN(din), .DOUT(dout), .DOUT_EN(den), .COMM_LOST(lost), .COS_PENDING(cos));
  diopl_field diopl_field_i (.field(field), .dout(dout), .dout_en(den), .din(din));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checked %0d, n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Reads note their expectation before the request so the monitor stays in order
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic er);
    int n;
    n = 0;
    if (!w) q.push_back({m, d, er});
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 100);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, e, m, 1'b0);
  endtask
  function automatic logic [15:0] crc16(input logic [31:0] w);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 31; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? 16'h8005 : 16'h0);
    return c;
  endfunction
  always @(posedge clk) begin
    if (psel && pen && !pwr && rdy === 1'b1 && q.size() > 0) begin
      x = q.pop_front();
      if (x.m != 32'h0) `CHK(prd & x.m, x.e)
      `CHK(err, x.er)
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h74ebaf89));
    tick(6);
    rstn <= 1'b1;
    rd(8'h00, '1, 32'h01E4_1041);
    rd(8'h0C, '1, 32'h0000_0041);
    rd(8'h10, '1, 32'h0000_0100);
    bus(1'b0, 8'h24, 32'h0, '1, 1'b1);
    $display("test reset done");
    wr(8'h10, 32'h000A_0A05);
    for (int i = 0; i < 4; i++) begin
      wr(8'h0C, ens[i][63:32]);
      tick(2);
      #1 `CHK(den, ens[i][31:0])
    end
    rd(8'h18, 32'h00FF_0000, 32'h0003_0000);
    rd(8'h18, 32'h00FF_0000, 32'h0);
    $display("test mapping done");
    for (int i = 0; i < 5; i++) begin
      wr(8'h14, {23'h0, cmds[i]} & 32'hFF);
      tick(2);
      #1 `CHK(dout[16], cmds[i][8])
    end
    $display("test commands done");
    wr(8'h00, 32'h0002_0851);
    tick(50);
    rd(8'h04, 32'h1, 32'h0);
    wr(8'h14, 32'h0A);
    tick(50);
    rd(8'h04, 32'h00FF_0001, 32'h0001_0001);
    rd(8'h20, 32'h3, 32'h3);
    rd(8'h20, 32'h3, 32'h1);
    rd(8'h20, 32'h1, 32'h0);
    $display("test priority done");
    for (int k = 0; k < 2; k++) begin
      wr(8'h00, {16'h0, k[0], 15'h1843});
      field <= $urandom() & ~32'h4;
      tick(60);
      rd(8'h04, 32'h1, {31'h0, k[0]});
      field[2] <= 1'b1;
      tick(4);
      field[2] <= 1'b0;
      tick(60);
      rd(8'h04, 32'h1, {31'h0, k[0]});
      field[2] <= 1'b1;
      tick(60);
      rd(8'h04, 32'h1, {31'h0, ~k[0]});
    end
    $display("test filter done");
    v = $urandom();
    field <= v;
    wr(8'h00, 32'h0000_0C01);
    tick(50);
    rd(8'h04, 32'h00FF_FFFF, {8'hFF, v[15:0]});
    rd(8'h08, 32'hFFFF, {16'h0, crc16(32'h0000_0C01)});
    $display("test word done");
    wr(8'h14, 32'h05);
    wr(8'h0C, 32'h0080_1051);
    wr(8'h14, 32'h0A);
    tick(8);
    #1 `CHK(dout[16], 1'b1)
    wr(8'h14, 32'h0A);
    tick(12);
    #1 `CHK(dout[16], 1'b1)
    tick(12);
    #1 `CHK(dout[16], 1'b0)
    $display("test pulse done");
    wr(8'h0C, 32'h0000_1051);
    wr(8'h14, 32'h05);
    lost <= 1'b1;
    tick(5);
    lost <= 1'b0;
    #1 `CHK(dout[16], 1'b0)
    wr(8'h10, 32'h010A_0A05);
    lost <= 1'b1;
    tick(5);
    lost <= 1'b0;
    #1 `CHK(dout[16], 1'b1)
    $display("test link done");
    // Reads drain what is pending so that only the interval can raise it again
    wr(8'h0C, 32'h0000_2851);
    repeat (3) rd(8'h20, 32'h0, 32'h0);
    for (int i = 0; i < 200 && cos[1] !== 1'b1; i++) tick(1);
    #1 `CHK(cos[1], 1'b1)
    wr(8'h0C, 32'h0000_0851);
    repeat (3) rd(8'h20, 32'h0, 32'h0);
    tick(150);
    #1 `CHK(cos[1], 1'b0)
    $display("test interval done");
    finish_test();
  end
  initial begin
    #200000;
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire
